/* hw/temp_sample_fifo_status.sv */
// sample fifo with count, lost-sample counter, threshold and apb registers
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "fifo_status_map.svh"

module temp_sample_fifo_status #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire fifo_status_pkg::sample_t sample_i,
   input  wire logic        force_roll_i,
   output logic      [AW-1:0] write_pointer_o,
   output logic      [AW-1:0] read_pointer_o,
   output logic             roll_on_full_o,
   output logic             almost_full_o,
   output logic             irq_o
);

   logic [AW-1:0] write_pointer_q;
   logic [AW-1:0] write_pointer_d;
   logic [AW-1:0] read_pointer_q;
   logic [AW-1:0] read_pointer_d;
   logic [6:0]    stored_count_q;
   logic [6:0]    stored_count_d;
   logic [5:0]    lost_sample_count_q;
   logic [5:0]    lost_sample_count_d;
   logic [5:0]    threshold_q;
   logic [5:0]    threshold_d;
   logic          roll_on_full_q;
   logic          roll_on_full_d;
   logic [7:0]    read_port_q;
   logic [7:0]    read_port_d;
   logic          almost_full_q;
   logic          almost_full_d;
   logic [31:0]   prdata_q;
   logic [31:0]   prdata_d;
   logic          pslverr_q;
   logic          pslverr_d;
   logic          pop_armed_q;
   logic          pop_armed_d;
   fifo_status_pkg::apb_state_t state_q;
   fifo_status_pkg::apb_state_t state_d;
   fifo_status_pkg::fifo_op_t   op;

   logic          full;
   logic          wr_access;
   logic          rd_access;
   logic          flush;
   logic          pop_req;
   logic          store_we;
   logic [7:0]    store_rd;
   logic [`FS_IRQ_WIDTH-1:0] irq_event;
   logic [`FS_IRQ_WIDTH-1:0] irq_clear;
   logic [`FS_IRQ_WIDTH-1:0] irq_status;
   logic [`FS_IRQ_WIDTH-1:0] irq_mask;
   logic          mask_we;

   function automatic logic addr_hit(input logic [11:0] a,
                                     input logic [11:0] off);
      return a == (off << 2);
   endfunction

   function automatic logic [6:0] level_of(input logic [5:0] thr);
      return 7'(`FS_DEPTH - {1'b0, thr});
   endfunction

   // apb: no wait cycle, ready in the first access cycle, answer taken in the setup phase
   always_comb begin
      state_d = state_q;
      case (state_q)
         fifo_status_pkg::APB_IDLE: begin
            if (psel_i && !penable_i) begin
               state_d = fifo_status_pkg::APB_ACCESS;
            end
         end
         fifo_status_pkg::APB_ACCESS: begin
            state_d = fifo_status_pkg::APB_IDLE;
         end
         default: state_d = fifo_status_pkg::APB_IDLE;
      endcase
   end

   assign pready_o  = state_q == fifo_status_pkg::APB_ACCESS;
   assign wr_access = pready_o && psel_i && penable_i && pwrite_i;
   assign rd_access = pready_o && psel_i && penable_i && !pwrite_i;

   // decode is registered in the setup cycle so data is a flop in access
   always_comb begin
      prdata_d    = prdata_q;
      pslverr_d   = pslverr_q;
      pop_armed_d = pop_armed_q;
      if (psel_i && !penable_i) begin
         pslverr_d   = 1'b0;
         pop_armed_d = 1'b0;
         prdata_d    = 32'h0000_0000;
         if (addr_hit(paddr_i, `FS_OFF_LOST_COUNT)) begin
            prdata_d[5:0] = lost_sample_count_q;
         end else if (addr_hit(paddr_i, `FS_OFF_STORED_COUNT)) begin
            prdata_d[6:0] = stored_count_q;
         end else if (addr_hit(paddr_i, `FS_OFF_READ_PORT)) begin
            // head sample; the pop happens when the access completes
            prdata_d[7:0] = (stored_count_q != 7'h00) ? store_rd
                                                    : read_port_q;
            // pop only what was shown; a push after setup stays stored
            pop_armed_d = stored_count_q != 7'h00;
         end else if (addr_hit(paddr_i, `FS_OFF_THRESHOLD)) begin
            prdata_d[5:0] = threshold_q;
         end else if (addr_hit(paddr_i, `FS_OFF_CONFIG2)) begin
            prdata_d[`FS_CONFIG_RO_BIT] = roll_on_full_q;
         end else if (addr_hit(paddr_i, `FS_OFF_IRQ_STATUS)) begin
            prdata_d[`FS_IRQ_WIDTH-1:0] = irq_status;
         end else if (addr_hit(paddr_i, `FS_OFF_IRQ_MASK)) begin
            prdata_d[`FS_IRQ_WIDTH-1:0] = irq_mask;
         end else if (addr_hit(paddr_i, `FS_OFF_POINTERS)) begin
            prdata_d[AW-1:0]   = write_pointer_q;
            prdata_d[AW+7:8]   = read_pointer_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      // a shown head that rolls away must not cost a second sample
      if (op.drop_oldest) begin
         pop_armed_d = 1'b0;
      end
   end

   // register writes; read-only addresses ignore writes silently
   assign mask_we = wr_access && addr_hit(paddr_i, `FS_OFF_IRQ_MASK)
                    && pstrb_i[0];
   assign flush   = wr_access && addr_hit(paddr_i, `FS_OFF_CONFIG2)
                    && pstrb_i[0] && pwdata_i[`FS_CONFIG_FLUSH_BIT];
   assign pop_req = rd_access && addr_hit(paddr_i, `FS_OFF_READ_PORT)
                    && pop_armed_q;

   always_comb begin
      irq_clear = '0;
      if (wr_access && addr_hit(paddr_i, `FS_OFF_IRQ_STATUS) && pstrb_i[0]) begin
         irq_clear = pwdata_i[`FS_IRQ_WIDTH-1:0];
      end
   end

   always_comb begin
      threshold_d    = threshold_q;
      roll_on_full_d = roll_on_full_q;
      if (wr_access && pstrb_i[0]) begin
         if (addr_hit(paddr_i, `FS_OFF_THRESHOLD)) begin
            threshold_d = pwdata_i[5:0];
         end
         if (addr_hit(paddr_i, `FS_OFF_CONFIG2)) begin
            roll_on_full_d = pwdata_i[`FS_CONFIG_RO_BIT];
         end
      end
   end

   assign full           = stored_count_q == `FS_DEPTH;
   assign roll_on_full_o = roll_on_full_q | force_roll_i;

   // push/pop decision; a pop in the same cycle frees a slot first
   always_comb begin
      op.push        = 1'b0;
      op.pop         = pop_req && (stored_count_q != 7'h00);
      op.drop_oldest = 1'b0;
      op.drop_newest = 1'b0;
      if (sample_i.valid && !flush) begin
         if (!full || op.pop) begin
            op.push = 1'b1;
         end else if (roll_on_full_o) begin
            op.push        = 1'b1;
            op.drop_oldest = 1'b1;
         end else begin
            op.drop_newest = 1'b1;
         end
      end
   end

   assign store_we = op.push;

   always_comb begin
      write_pointer_d     = write_pointer_q;
      read_pointer_d      = read_pointer_q;
      stored_count_d      = stored_count_q;
      lost_sample_count_d = lost_sample_count_q;
      read_port_d         = read_port_q;
      if (op.push) begin
         write_pointer_d = write_pointer_q + 1'b1;
      end
      if (op.pop || op.drop_oldest) begin
         read_pointer_d = read_pointer_q + 1'b1;
      end
      if (op.pop) begin
         read_port_d = store_rd;
      end
      // count stays at 64 when the oldest is overwritten
      if (op.push && !op.pop && !op.drop_oldest) begin
         stored_count_d = stored_count_q + 7'h01;
      end else if (op.pop && !op.push) begin
         stored_count_d = stored_count_q - 7'h01;
      end
      if ((op.drop_oldest || op.drop_newest)
          && lost_sample_count_q != `FS_LOST_MAX) begin
         lost_sample_count_d = lost_sample_count_q + 6'h01;
      end
      if (flush) begin
         write_pointer_d     = '0;
         read_pointer_d      = '0;
         stored_count_d      = 7'h00;
         lost_sample_count_d = 6'h00;
      end
   end

   // level only rises on the crossing, so the event fires once
   always_comb begin
      almost_full_d = stored_count_q >= level_of(threshold_q);
   end

   always_comb begin
      irq_event = '0;
      irq_event[`FS_IRQ_ALMOST_FULL] = almost_full_d && !almost_full_q;
      irq_event[`FS_IRQ_OVERFLOW]    = op.drop_oldest | op.drop_newest;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q             <= fifo_status_pkg::APB_IDLE;
         prdata_q            <= 32'h0000_0000;
         pslverr_q           <= 1'b0;
         pop_armed_q         <= 1'b0;
         write_pointer_q     <= '0;
         read_pointer_q      <= '0;
         stored_count_q      <= 7'h00;
         lost_sample_count_q <= 6'h00;
         threshold_q         <= `FS_THRESHOLD_RESET;
         roll_on_full_q      <= 1'b0;
         read_port_q         <= 8'h00;
         almost_full_q       <= 1'b0;
      end else begin
         state_q             <= state_d;
         prdata_q            <= prdata_d;
         pslverr_q           <= pslverr_d;
         pop_armed_q         <= pop_armed_d;
         write_pointer_q     <= write_pointer_d;
         read_pointer_q      <= read_pointer_d;
         stored_count_q      <= stored_count_d;
         lost_sample_count_q <= lost_sample_count_d;
         threshold_q         <= threshold_d;
         roll_on_full_q      <= roll_on_full_d;
         read_port_q         <= read_port_d;
         almost_full_q       <= almost_full_d;
      end
   end

   sample_store #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_store (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .wr_en_i   (store_we),
      .wr_addr_i (write_pointer_q),
      .wr_data_i (sample_i.data),
      .rd_addr_i (read_pointer_q),
      .rd_data_o (store_rd)
   );

   irq_block #(
      .W (`FS_IRQ_WIDTH)
   ) u_irq (
      .ref_clk_i    (ref_clk_i),
      .rst_b_i      (rst_b_i),
      .event_i      (irq_event),
      .clear_i      (irq_clear),
      .mask_we_i    (mask_we),
      .mask_wdata_i (pwdata_i[`FS_IRQ_WIDTH-1:0]),
      .status_o     (irq_status),
      .mask_o       (irq_mask),
      .irq_o        (irq_o)
   );

   assign prdata_o        = prdata_q;
   assign pslverr_o       = pslverr_q & pready_o;
   assign write_pointer_o = write_pointer_q;
   assign read_pointer_o  = read_pointer_q;
   assign almost_full_o   = almost_full_q;

endmodule // temp_sample_fifo_status

/* include/fifo_status_map.svh */
// register offsets, fields, reset values and sizes of the sample fifo status
`ifndef FIFO_STATUS_MAP_SVH
`define FIFO_STATUS_MAP_SVH

`define FS_OFF_LOST_COUNT   12'h006
`define FS_OFF_STORED_COUNT 12'h007
`define FS_OFF_READ_PORT    12'h008
`define FS_OFF_THRESHOLD    12'h009
`define FS_OFF_CONFIG2      12'h00a
`define FS_OFF_IRQ_STATUS   12'h00c
`define FS_OFF_IRQ_MASK     12'h00d
`define FS_OFF_POINTERS     12'h00e

`define FS_THRESHOLD_RESET  6'h1f
`define FS_CONFIG_RO_BIT    1
`define FS_CONFIG_FLUSH_BIT 4
`define FS_LOST_MAX         6'h3f
`define FS_DEPTH            7'h40

`define FS_IRQ_ALMOST_FULL  0
`define FS_IRQ_OVERFLOW     1
`define FS_IRQ_WIDTH        2

`endif

/* include/fifo_status_pkg.sv */
// types shared by the sample fifo status block
package fifo_status_pkg;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } sample_t;

   typedef struct packed {
      logic       push;
      logic       pop;
      logic       drop_oldest;
      logic       drop_newest;
   } fifo_op_t;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_ACCESS = 2'b01
   } apb_state_t;

endpackage

/* hw/sample_store.sv */
// flip-flop sample storage, one write and one read location per cycle
`timescale 1ns/1ps

module sample_store #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic          ref_clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [7:0]    wr_data_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [7:0]    rd_data_o
);

   logic [7:0] mem_q [DEPTH];
   logic [7:0] mem_d [DEPTH];

   always_comb begin
      mem_d = mem_q;
      if (wr_en_i) begin
         mem_d[wr_addr_i] = wr_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else begin
         mem_q <= mem_d;
      end
   end

   assign rd_data_o = mem_q[rd_addr_i];

endmodule // sample_store

/* hw/irq_block.sv */
// sticky interrupt status, write-one-to-clear, with mask and level output
`timescale 1ns/1ps

module irq_block #(
   parameter int W = 2
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] event_i,
   input  wire logic [W-1:0] clear_i,
   input  wire logic         mask_we_i,
   input  wire logic [W-1:0] mask_wdata_i,
   output logic      [W-1:0] status_o,
   output logic      [W-1:0] mask_o,
   output logic              irq_o
);

   logic [W-1:0] status_q;
   logic [W-1:0] status_d;
   logic [W-1:0] mask_q;
   logic [W-1:0] mask_d;

   always_comb begin
      // set wins over a clear in the same cycle
      status_d = (status_q & ~clear_i) | event_i;
      mask_d   = mask_we_i ? mask_wdata_i : mask_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_q <= '0;
         mask_q   <= '0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
      end
   end

   assign status_o = status_q;
   assign mask_o   = mask_q;
   assign irq_o    = |(status_q & mask_q);

endmodule // irq_block

/* test/fifo_status_asserts.sv */
// concurrent checks on the sample fifo status ports
`timescale 1ns/1ps
module fifo_status_asserts #(
   parameter int AW = 6
) (
   input wire logic          ref_clk_i,
   input wire logic          rst_b_i,
   input wire logic          psel_i,
   input wire logic          penable_i,
   input wire logic          pwrite_i,
   input wire logic [11:0]   paddr_i,
   input wire fifo_status_pkg::sample_t sample_i,
   input wire logic          force_roll_i,
   input wire logic          pready_o,
   input wire logic          pslverr_o,
   input wire logic [AW-1:0] write_pointer_o,
   input wire logic [AW-1:0] read_pointer_o,
   input wire logic          roll_on_full_o,
   input wire logic          almost_full_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   chk_err_unmapped: assert property (pready_o && paddr_i == 12'h02c
      |-> pslverr_o) else $error("unmapped access without error");
   chk_err_mapped: assert property (pready_o && paddr_i == 12'h01c
      |-> !pslverr_o) else $error("mapped access with error");
   chk_wptr_step: assert property ($changed(write_pointer_o) |->
      write_pointer_o == $past(write_pointer_o) + 1'b1 ||
      write_pointer_o == '0) else $error("write pointer jump");
   chk_wptr_cause: assert property ($changed(write_pointer_o) |->
      $past(sample_i.valid) || $past(pwrite_i && pready_o))
      else $error("write pointer moved without sample");
   chk_rptr_step: assert property ($changed(read_pointer_o) |->
      read_pointer_o == $past(read_pointer_o) + 1'b1 ||
      read_pointer_o == '0) else $error("read pointer jump");
   chk_roll_force: assert property (force_roll_i |-> roll_on_full_o)
      else $error("forced roll not shown");
   chk_af_cause: assert property ($rose(almost_full_o) |->
      $past(sample_i.valid, 2) || $past(pwrite_i && pready_o, 2))
      else $error("almost full rose without cause");
   cover property ($rose(almost_full_o));
   cover property (pready_o && pslverr_o);
   cover property ($changed(read_pointer_o) && $changed(write_pointer_o));
endmodule // fifo_status_asserts

bind temp_sample_fifo_status fifo_status_asserts #(.AW(AW))
   i_fifo_status_asserts (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .sample_i(sample_i), .force_roll_i(force_roll_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o),
   .write_pointer_o(write_pointer_o), .read_pointer_o(read_pointer_o),
   .roll_on_full_o(roll_on_full_o), .almost_full_o(almost_full_o));

/* test/sample_source.sv */
// conversion side model: one sample a cycle, counting data
`timescale 1ns/1ps
module sample_source (
   input  wire logic               ref_clk_i,
   output fifo_status_pkg::sample_t sample_o
);
   logic [7:0] next_q;
   initial begin
      next_q   = 8'h10;
      sample_o = '0;
   end
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk_i);
         sample_o <= '{1'b1, next_q};
         next_q   <= next_q + 8'h01;
      end
      @(posedge ref_clk_i);
      // idle data flips so a stale byte is never mistaken for a sample
      sample_o <= '{1'b0, ~sample_o.data};
   endtask
endmodule // sample_source

/* test/tb_top.sv */
// register level testbench for the sample fifo status block
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst_b, psel, penable, pwrite, frc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, af, irq, rof;
   logic [5:0]  wp, rp;
   fifo_status_pkg::sample_t smp;
   int          failures, samples_checked, cyc;

   temp_sample_fifo_status i_temp_sample_fifo_status (
      .ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sample_i(smp),
      .force_roll_i(frc), .write_pointer_o(wp), .read_pointer_o(rp),
      .roll_on_full_o(rof), .almost_full_o(af), .irq_o(irq));
   sample_source i_sample_source (.ref_clk_i(clk), .sample_o(smp));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      // generous ceiling, the full run needs about two hundred and fifty cycles
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request holds until pready is seen high at a rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask

   initial begin
      logic [31:0] r;
      logic        e;
      {rst_b, psel, penable, pwrite, frc, paddr, pwdata, cyc} = '0;
      pstrb = 4'hf;
      failures = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd(12'h018, 32'h0);
      rd(12'h01c, 32'h0);
      rd(12'h020, 32'h0);
      rd(12'h024, 32'h1f);
      rd(12'h034, 32'h0);
      $display("test reset values done");
      wr(12'h024, 32'h0000_00cf);
      rd(12'h024, 32'h0f);
      pstrb <= 4'he;
      wr(12'h024, 32'h3);
      pstrb <= 4'hf;
      rd(12'h024, 32'h0f);
      wr(12'h01c, 32'h5);
      rd(12'h01c, 32'h0);
      apb(1'b0, 12'h02c, 32'h0, r, e);
      chk(32'(e), 32'h1);
      $display("test access kinds done");
      i_sample_source.send(48);
      rd(12'h01c, 32'd48);
      chk(32'(af), 32'h0);
      i_sample_source.send(1);
      rd(12'h01c, 32'd49);
      chk(32'(af), 32'h1);
      chk(32'(wp), 32'h31);
      wr(12'h034, 32'h1);
      // registers written at the completing edge show one edge later
      @(posedge clk);
      chk(32'(irq), 32'h1);
      wr(12'h030, 32'h1);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      $display("test almost full done");
      i_sample_source.send(15);
      rd(12'h01c, 32'd64);
      i_sample_source.send(2);
      rd(12'h01c, 32'd64);
      rd(12'h018, 32'h2);
      chk(32'({wp, rp}), 32'h0);
      rd(12'h030, 32'h2);
      wr(12'h030, 32'h2);
      rd(12'h030, 32'h0);
      $display("test full drop newest done");
      rd(12'h020, 32'h10);
      rd(12'h01c, 32'd63);
      i_sample_source.send(1);
      wr(12'h028, 32'h2);
      @(posedge clk);
      chk(32'(rof), 32'h1);
      i_sample_source.send(1);
      rd(12'h018, 32'h3);
      chk(32'({wp, rp}), 32'h82);
      rd(12'h020, 32'h12);
      rd(12'h038, 32'h0302);
      $display("test roll on full done");
      wr(12'h028, 32'h0);
      frc <= 1'b1;
      i_sample_source.send(62);
      rd(12'h01c, 32'd64);
      rd(12'h018, 32'h3f);
      frc <= 1'b0;
      $display("test lost count saturation done");
      wr(12'h028, 32'h10);
      rd(12'h01c, 32'h0);
      rd(12'h018, 32'h0);
      rd(12'h038, 32'h0);
      rd(12'h028, 32'h0);
      $display("test flush done");
      end_sim();
   end
endmodule // tb_top
